// *** hw/adc_ctrl_pkg.sv ***
// constants, field layout and types for the converter control register bank
// assumes a single 200 MHz clock domain and a 12-bit host data bus
package adc_ctrl_pkg;

    // ****************************************************************
    // bus layout
    // ****************************************************************
    localparam int HOST_BUS_W = 12;
    localparam int REG_W = 10;
    localparam int ADDR_LSB = 10;
    localparam int ADDR_W = 2;

    // register selects on the two upper data lines
    localparam logic [1:0] ADDR_CONVERSION_SETUP = 2'h0;
    localparam logic [1:0] ADDR_OUTPUT_AND_FIFO_SETUP = 2'h1;

    // ****************************************************************
    // conversion_setup fields
    // ****************************************************************
    localparam int BIT_REF_SELECT = 0;
    localparam int BIT_SINGLE_MODE = 1;
    localparam int BIT_POWER_DOWN = 2;
    localparam int BIT_INPUT_PICK_LO = 3;
    localparam int BIT_BALANCED_LO = 5;
    localparam int BIT_AUTOSCAN = 7;
    localparam int BIT_DIAG_LO = 8;
    localparam int INPUT_CFG_LSB = 3;
    localparam int INPUT_CFG_W = 5;
    localparam int DIAG_W = 2;

    localparam logic [9:0] CONVERSION_SETUP_RESET = 10'h020;
    // second register has no defined reset; cleared
    localparam logic [9:0] OUTPUT_AND_FIFO_SETUP_RESET = 10'h000;

    localparam logic [1:0] DIAG_NORMAL = 2'h0;
    localparam logic [1:0] DIAG_POS_REF = 2'h1;
    localparam logic [1:0] DIAG_MID_REF = 2'h2;
    localparam logic [1:0] DIAG_NEG_REF = 2'h3;

    // ****************************************************************
    // input channel codes: {differential, pair/index}
    // ****************************************************************
    typedef logic [2:0] chan_t;
    localparam chan_t CH_AP = 3'h0;
    localparam chan_t CH_AM = 3'h1;
    localparam chan_t CH_BP = 3'h2;
    localparam chan_t CH_BM = 3'h3;
    localparam chan_t CH_DIFF_A = 3'h4;
    localparam chan_t CH_DIFF_B = 3'h5;

    localparam int SEQ_IDX_W = 2;
    localparam int SEQ_LEN_W = 3;
    localparam int TRIG_W = 5;

    // ****************************************************************
    // sequencer states, gray along idle -> request -> wait
    // ****************************************************************
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_REQ = 2'b01,
        S_WAIT = 2'b11
    } seq_state_t;

endpackage

// *** hw/adc_control_register_bank.sv ***
// control register bank and conversion sequencer of a four-input sampling converter
// assumes host pins and the sample clock pin are asynchronous; core and fifo share clock
`timescale 1ns/1ps
`default_nettype none

module adc_control_register_bank
    import adc_ctrl_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // host parallel bus pins
    input wire logic [HOST_BUS_W-1:0] hostDataIn,
    output logic [HOST_BUS_W-1:0] hostDataOut,
    output logic hostDataDriveN,
    input wire logic chipSelectN,
    input wire logic hostWriteN,
    input wire logic hostReadN,
    // sample clock / start pin
    input wire logic sampleClockIn,
    // sampling core
    output logic holdStrobe,
    output logic convRequest,
    output chan_t convChannel,
    input wire logic coreValid,
    input wire logic [SAMPLE_W-1:0] coreData,
    // configuration seen by the core
    output logic refSelect,
    output logic powerDownBit,
    output logic [DIAG_W-1:0] diagVoltage,
    output logic [REG_W-1:0] outputAndFifoSetup,
    // fifo write side
    output logic fifoWrValid,
    output logic [SAMPLE_W-1:0] fifoWrData,
    input wire logic fifoWrReady,
    input wire logic [TRIG_W-1:0] fifoTriggerLevel,
    // status
    output logic blockReadyOutN,
    output logic missedStart
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam int SYNC_W = HOST_BUS_W + 4;
    logic [SYNC_W-1:0] pinMeta;
    logic [SYNC_W-1:0] pinSync;
    logic writeNPrev;
    logic sampleClkPrev;
    // two flops per pin; the data word is used only after its strobe settles

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pinMeta <= '1;
            pinSync <= '1;
        end else begin
            pinMeta <= {hostDataIn, chipSelectN, hostWriteN, hostReadN, sampleClockIn};
            pinSync <= pinMeta;
        end
    end

    logic [HOST_BUS_W-1:0] syncData;
    logic syncCsN;
    logic syncWrN;
    logic syncRdN;
    logic syncSampleClk;
    assign {syncData, syncCsN, syncWrN, syncRdN, syncSampleClk} = pinSync;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            writeNPrev <= 1'b1;
            sampleClkPrev <= 1'b0;
        end else begin
            writeNPrev <= syncWrN;
            sampleClkPrev <= syncSampleClk;
        end
    end

    // data is latched on the closing edge of the strobe, when it is settled
    logic hostWrite;
    logic startEdge;
    assign hostWrite = syncWrN && !writeNPrev && !syncCsN;
    assign startEdge = sampleClkPrev && !syncSampleClk;

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [REG_W-1:0] conversionSetup;
    logic [ADDR_W-1:0] writeAddr;
    logic cfgWrite;
    assign writeAddr = syncData[ADDR_LSB +: ADDR_W];
    assign cfgWrite = hostWrite && (writeAddr == ADDR_CONVERSION_SETUP);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            conversionSetup <= CONVERSION_SETUP_RESET;
            outputAndFifoSetup <= OUTPUT_AND_FIFO_SETUP_RESET;
        end else if (hostWrite) begin
            // power down gates conversions only, never this path
            unique case (writeAddr)
                ADDR_CONVERSION_SETUP: conversionSetup <= syncData[REG_W-1:0];
                ADDR_OUTPUT_AND_FIFO_SETUP: outputAndFifoSetup <= syncData[REG_W-1:0];
                default: ;
            endcase
        end
    end

    assign refSelect = conversionSetup[BIT_REF_SELECT];
    assign powerDownBit = conversionSetup[BIT_POWER_DOWN];
    assign diagVoltage = conversionSetup[BIT_DIAG_LO +: DIAG_W];

    logic singleMode;
    logic [INPUT_CFG_W-1:0] inputCfg;
    logic testActive;
    assign singleMode = conversionSetup[BIT_SINGLE_MODE];
    assign inputCfg = conversionSetup[INPUT_CFG_LSB +: INPUT_CFG_W];
    assign testActive = diagVoltage != DIAG_NORMAL;

    // readback of register 0 with its address bits, driven only during a read
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hostDataOut <= '0;
            hostDataDriveN <= 1'b1;
        end else begin
            hostDataOut <= {ADDR_CONVERSION_SETUP, conversionSetup};
            hostDataDriveN <= syncRdN || syncCsN;
        end
    end

    // ****************************************************************
    // channel order table
    // ****************************************************************
    // config is {autoscan, balanced hi, balanced lo, pick hi, pick lo}
    function automatic logic [SEQ_LEN_W-1:0] seqLen(input logic [INPUT_CFG_W-1:0] cfg);
        unique case (cfg)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: seqLen = 3'h1;
            5'h11, 5'h15, 5'h19: seqLen = 3'h2;
            5'h12, 5'h16: seqLen = 3'h3;
            5'h13: seqLen = 3'h4;
            default: seqLen = 3'h0; // reserved: nothing converts
        endcase
    endfunction

    function automatic chan_t seqChan(input logic [INPUT_CFG_W-1:0] cfg,
                                      input logic [SEQ_IDX_W-1:0] idx);
        unique case (cfg)
            5'h04: seqChan = CH_DIFF_A;
            5'h05: seqChan = CH_DIFF_B;
            5'h15: seqChan = (idx == 2'h0) ? CH_AP : CH_DIFF_B;
            5'h16: seqChan = (idx == 2'h2) ? CH_DIFF_B : chan_t'({1'b0, idx});
            5'h19: seqChan = (idx == 2'h0) ? CH_DIFF_A : CH_DIFF_B;
            default: seqChan = chan_t'({1'b0, (cfg[4] ? idx : cfg[1:0])});
        endcase
    endfunction

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    seq_state_t state;
    logic [SEQ_IDX_W-1:0] seqIdx;
    logic [SEQ_LEN_W-1:0] curLen;
    logic convEnabled;
    logic lastIdx;
    logic bufRoom;
    logic spareValid;
    assign curLen = seqLen(inputCfg);
    // reserved input codes and power down leave the sequencer idle
    assign convEnabled = !powerDownBit && (curLen != 3'h0);
    assign lastIdx = {1'b0, seqIdx} == (curLen - 3'h1);
    // one request outstanding, so room checked at request time suffices
    assign bufRoom = !(fifoWrValid && spareValid);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: if (startEdge && convEnabled) state <= S_REQ;
                S_REQ: if (bufRoom) state <= S_WAIT;
                S_WAIT: begin
                    if (coreValid) begin
                        // single mode walks the whole order; continuous takes one
                        state <= (singleMode && !lastIdx) ? S_REQ : S_IDLE;
                    end
                end
                default: state <= S_IDLE; // an upset code falls back to idle
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            seqIdx <= '0;
        end else if (cfgWrite) begin
            // a new setup restarts the order at its first input
            seqIdx <= '0;
        end else if (state == S_WAIT && coreValid) begin
            seqIdx <= lastIdx ? '0 : seqIdx + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            holdStrobe <= 1'b0;
            convRequest <= 1'b0;
            convChannel <= CH_AP;
            missedStart <= 1'b0;
        end else begin
            // pulses leave flops so the core sees no glitches
            holdStrobe <= (state == S_IDLE) && startEdge && convEnabled && singleMode;
            convRequest <= (state == S_REQ) && bufRoom;
            if (state == S_REQ) begin
                convChannel <= seqChan(inputCfg, seqIdx);
            end
            // an edge during a running conversion is dropped, not queued
            missedStart <= startEdge && (state != S_IDLE);
        end
    end

    // ****************************************************************
    // two-entry buffer toward the fifo
    // ****************************************************************
    logic [SAMPLE_W-1:0] spareData;
    logic push;
    logic pop;
    assign push = (state == S_WAIT) && coreValid;
    assign pop = fifoWrValid && fifoWrReady;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fifoWrValid <= 1'b0;
            fifoWrData <= '0;
            spareValid <= 1'b0;
            spareData <= '0;
        end else if (pop) begin
            fifoWrValid <= spareValid || push;
            fifoWrData <= spareValid ? spareData : coreData;
            spareValid <= spareValid && push;
            if (push) begin
                spareData <= coreData;
            end
        end else if (push) begin
            if (!fifoWrValid) begin
                fifoWrValid <= 1'b1;
                fifoWrData <= coreData;
            end else begin
                spareValid <= 1'b1;
                spareData <= coreData;
            end
        end
    end

    // ****************************************************************
    // trigger counter and data-available
    // ****************************************************************
    logic [TRIG_W-1:0] trigCount;
    logic [TRIG_W-1:0] trigLevel;
    logic trigHit;
    // a level of zero would fire on every word; treated as one
    assign trigLevel = (fifoTriggerLevel == '0) ? TRIG_W'(1) : fifoTriggerLevel;
    assign trigHit = (trigCount + TRIG_W'(1)) >= trigLevel;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            trigCount <= '0;
            blockReadyOutN <= 1'b1;
        end else begin
            // a new setup restarts the block count too
            if (cfgWrite) begin
                trigCount <= '0;
            end else if (pop) begin
                trigCount <= trigHit ? '0 : trigCount + TRIG_W'(1);
            end
            // active-low one-cycle pulse per completed block outside test operation
            blockReadyOutN <= !(pop && trigHit && !testActive);
        end
    end

endmodule // adc_control_register_bank

`default_nettype wire

// *** testbench/adc_core_model.sv ***
// behavioural sampling core that answers conversion requests of the bank
// assumes one request outstanding at a time and the bank's own clock
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // request and answer
    input wire logic convRequest,
    input wire logic [2:0] convChannel,
    input wire logic slow,
    output logic coreValid,
    output logic [11:0] coreData
);
    logic busy;
    logic [2:0] chan;
    logic [3:0] delay;
    logic [11:0] churn;
    // result bus churns between answers so a stale word never looks valid
    always_ff @(posedge clock) begin
        churn <= churn + 12'h3c5;
        coreData <= churn;
        coreValid <= 1'b0;
        if (!reset_n) begin
            busy <= 1'b0;
            churn <= 12'h000;
        end else if (convRequest) begin
            busy <= 1'b1;
            chan <= convChannel;
            delay <= slow ? 4'h6 : 4'h0;
        end else if (busy && delay != 4'h0) begin
            delay <= delay - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            coreValid <= 1'b1;
            coreData <= {9'h1a5, chan};
        end
    end
endmodule // adc_core_model
`default_nettype wire

// *** testbench/adc_control_register_bank_checker.sv ***
// port assertions for the converter control register bank
// assumes it is bound onto adc_control_register_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank_checker
    import adc_ctrl_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // watched ports
    input wire logic [HOST_BUS_W-1:0] hostDataOut,
    input wire logic hostDataDriveN,
    input wire logic holdStrobe,
    input wire logic convRequest,
    input wire chan_t convChannel,
    input wire logic coreValid,
    input wire logic [SAMPLE_W-1:0] coreData,
    input wire logic refSelect,
    input wire logic powerDownBit,
    input wire logic [DIAG_W-1:0] diagVoltage,
    input wire logic [REG_W-1:0] outputAndFifoSetup,
    input wire logic fifoWrValid,
    input wire logic [SAMPLE_W-1:0] fifoWrData,
    input wire logic fifoWrReady,
    input wire logic blockReadyOutN
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    reset_vals_a: assert property ($rose(reset_n) |-> !refSelect && !powerDownBit &&
        diagVoltage == 2'h0 && outputAndFifoSetup == 10'h000 && blockReadyOutN
        && hostDataDriveN ##1 hostDataOut == 12'h020) else $error("bad state after reset");
    readback_a: assert property (!hostDataDriveN |-> hostDataOut[11:10] == 2'h0 &&
        hostDataOut[0] == refSelect && hostDataOut[2] == powerDownBit
        && hostDataOut[9:8] == diagVoltage) else $error("readback disagrees with outputs");
    hold_first_a: assert property (holdStrobe |-> hostDataOut[1] ##[1:20] convRequest)
        else $error("hold without single mode or request");
    conv_pulse_a: assert property (convRequest |=> !convRequest)
        else $error("request longer than one cycle");
    chan_hold_a: assert property (convRequest |-> convChannel <= 3'h5 ##1
        $stable(convChannel)) else $error("bad or moving channel");
    fifo_load_a: assert property (coreValid && !fifoWrValid |=> fifoWrValid &&
        fifoWrData == $past(coreData)) else $error("result not loaded");
    fifo_hold_a: assert property (fifoWrValid && !fifoWrReady |=> fifoWrValid &&
        $stable(fifoWrData)) else $error("stalled word lost");
    ready_cause_a: assert property ($fell(blockReadyOutN) |->
        $past(fifoWrValid && fifoWrReady)) else $error("data available without a write");
    ready_in_test_a: assert property (diagVoltage != 2'h0 && $past(diagVoltage) != 2'h0
        |-> blockReadyOutN) else $error("data available in test operation");
endmodule // adc_control_register_bank_checker
bind adc_control_register_bank adc_control_register_bank_checker #(.SAMPLE_W(SAMPLE_W)) chk (
    .clock(clock), .reset_n(reset_n), .hostDataOut(hostDataOut),
    .hostDataDriveN(hostDataDriveN), .holdStrobe(holdStrobe), .convRequest(convRequest),
    .convChannel(convChannel), .coreValid(coreValid), .coreData(coreData),
    .refSelect(refSelect), .powerDownBit(powerDownBit), .diagVoltage(diagVoltage),
    .outputAndFifoSetup(outputAndFifoSetup), .fifoWrValid(fifoWrValid),
    .fifoWrData(fifoWrData), .fifoWrReady(fifoWrReady), .blockReadyOutN(blockReadyOutN));
`default_nettype wire

// *** testbench/test_adc_control_register_bank.sv ***
// self-checking bench: host bus tasks, sample pin strikes, fifo side monitor
// assumes the core model answers every request; fifo side driven here
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_register_bank;
    import adc_ctrl_pkg::*;
    logic clock, reset_n, chipSelectN, hostWriteN, hostReadN, sampleClockIn, fifoWrReady, slow;
    logic [11:0] hostDataIn, hostDataOut, fifoWrData, coreData;
    logic hostDataDriveN, holdStrobe, convRequest, coreValid, refSelect, powerDownBit;
    logic fifoWrValid, blockReadyOutN, missedStart;
    chan_t convChannel;
    logic [1:0] diagVoltage;
    logic [9:0] outputAndFifoSetup;
    logic [4:0] fifoTriggerLevel;
    int fail_count = 0, n_tests = 0, rdy = 0, miss = 0;
    logic [11:0] got[$];
    localparam logic [4:0] cfg [6] = '{5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
    localparam logic [11:0] seq [6] = '{12'h008, 12'h088, 12'h688, 12'h028, 12'h148, 12'h02c};
    localparam int cnt [6] = '{2, 3, 4, 2, 3, 2};
    adc_control_register_bank dut (.clock(clock), .reset_n(reset_n), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataDriveN(hostDataDriveN), .chipSelectN(chipSelectN),
        .hostWriteN(hostWriteN), .hostReadN(hostReadN), .sampleClockIn(sampleClockIn),
        .holdStrobe(holdStrobe), .convRequest(convRequest), .convChannel(convChannel),
        .coreValid(coreValid), .coreData(coreData), .refSelect(refSelect),
        .powerDownBit(powerDownBit), .diagVoltage(diagVoltage),
        .outputAndFifoSetup(outputAndFifoSetup), .fifoWrValid(fifoWrValid),
        .fifoWrData(fifoWrData), .fifoWrReady(fifoWrReady),
        .fifoTriggerLevel(fifoTriggerLevel), .blockReadyOutN(blockReadyOutN),
        .missedStart(missedStart));
    adc_core_model core (.clock(clock), .reset_n(reset_n), .convRequest(convRequest),
        .convChannel(convChannel), .slow(slow), .coreValid(coreValid), .coreData(coreData));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // fifo side monitor
    always @(posedge clock) begin
        if (fifoWrValid && fifoWrReady) got.push_back(fifoWrData);
        if (blockReadyOutN === 1'b0) rdy++;
        if (missedStart === 1'b1) miss++;
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // strobe held well past the two-flop pin synchroniser
    task automatic wr(input logic [1:0] a, input logic [9:0] v);
        hostDataIn <= {a, v};
        chipSelectN <= 1'b0;
        hostWriteN <= 1'b0;
        cyc(4);
        hostWriteN <= 1'b1;
        cyc(5);
        chipSelectN <= 1'b1;
        cyc(1);
    endtask
    task automatic rd(input logic [11:0] exp);
        chipSelectN <= 1'b0;
        hostReadN <= 1'b0;
        cyc(5);
        chk({11'h0, hostDataDriveN}, 12'h000);
        chk(hostDataOut, exp);
        hostReadN <= 1'b1;
        chipSelectN <= 1'b1;
        cyc(5);
    endtask
    task automatic strike();
        sampleClockIn <= 1'b0;
        cyc(4);
        sampleClockIn <= 1'b1;
        cyc(4);
    endtask
    task automatic collect(input int n);
        for (int i = 0; i < 300 && got.size() < n; i++) cyc(1);
        // let the last word's data-available pulse land first
        cyc(2);
        chk(12'(got.size()), 12'(n));
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        cyc(20000);
        fail_count++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        hostDataIn = 12'h000;
        chipSelectN = 1'b1;
        hostWriteN = 1'b1;
        hostReadN = 1'b1;
        sampleClockIn = 1'b1;
        fifoWrReady = 1'b1;
        fifoTriggerLevel = 5'h01;
        slow = 1'b0;
        cyc(6);
        reset_n <= 1'b1;
        cyc(2);
        rd(12'h020);
        wr(2'h1, 10'h155);
        wr(2'h2, 10'h3ff);
        wr(2'h3, 10'h3ff);
        chk({2'h0, outputAndFifoSetup}, 12'h155);
        rd(12'h020);
        wr(2'h0, 10'h001);
        chk({11'h0, refSelect}, 12'h001);
        // continuous mode on one input, trigger on every word
        wr(2'h0, 10'h010);
        got.delete();
        rdy = 0;
        strike();
        strike();
        collect(2);
        chk(got[1], 12'hd2a);
        chk(12'(rdy), 12'h002);
        // single mode through every scan order, slow core on odd rows
        for (int i = 0; i < 6; i++) begin
            fifoTriggerLevel <= 5'(cnt[i]);
            slow <= i[0];
            wr(2'h0, {2'h0, cfg[i], 3'h2});
            got.delete();
            rdy = 0;
            if (i == 2) fifoWrReady <= 1'b0;
            strike();
            if (i == 2) cyc(40);
            fifoWrReady <= 1'b1;
            collect(cnt[i]);
            for (int k = 0; k < cnt[i]; k++) chk(got[k], 12'hd28 + seq[i][3*k +: 3]);
            chk(12'(rdy), 12'h001);
        end
        // reserved pick, then power down: strikes must do nothing
        got.delete();
        for (int i = 0; i < 2; i++) begin
            wr(2'h0, i ? 10'h006 : 10'h032);
            strike();
        end
        cyc(40);
        chk(12'(got.size()), 12'h000);
        rd(12'h006);
        // second strike lands while a slow four-input scan is busy
        wr(2'h0, 10'h09a);
        got.delete();
        miss = 0;
        strike();
        strike();
        cyc(60);
        chk(12'(got.size()), 12'h004);
        chk(12'(miss), 12'h001);
        fifoTriggerLevel <= 5'h01;
        for (int d = 1; d < 4; d++) begin
            wr(2'h0, {d[1:0], 8'h02});
            rdy = 0;
            strike();
            cyc(30);
            chk({10'h0, diagVoltage}, 12'(d));
            chk(12'(rdy), 12'h000);
        end
        // leaving test operation takes a fresh setup write
        wr(2'h0, 10'h02a);
        got.delete();
        rdy = 0;
        strike();
        collect(1);
        chk(got[0], 12'hd2d);
        chk(12'(rdy), 12'h001);
        test_done();
    end
endmodule // test_adc_control_register_bank
`default_nettype wire
